// file: bench/psc_counters_sva.sv
// apb timing checker for the statistics counter bank
`timescale 1ns/1ps
module psc_counters_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  import psc_pkg::*;
  logic mapped;
  assign mapped = paddr inside {ADDR_ACCESS_CTRL, ADDR_DATA_LOW, ADDR_DATA_HIGH, ADDR_MAX_LEN};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_RDY_LAT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  AST_UNMAPPED: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  AST_MAPPED: assert property (pready && mapped |-> !pslverr)
    else $error("mapped refused");
  AST_HIGH_WORD: assert property (pready && !pwrite && paddr == ADDR_DATA_HIGH
    |-> prdata[31:16] == 16'h0) else $error("high word wide");
  AST_MAXLEN: assert property (pready && !pwrite && paddr == ADDR_MAX_LEN
    |-> prdata <= 32'h7d0) else $error("max length above top");
endmodule : psc_counters_chk
bind psc_counters psc_counters_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr));

// file: bench/psc_counters_tb_top.sv
// self-checking bench for the port statistics counter bank
`timescale 1ns/1ps
module psc_counters_tb_top;
  import psc_pkg::*;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, v;
  logic [2:0]       rx_done, rx_high_prio, rx_check_bad, rx_symbol_bad, rx_partial_byte;
  logic [2:0]       rx_bcast, rx_mcast, rx_ctrl_type, rx_dest_ok, rx_hold_opcode;
  logic [2:0]       tx_done, tx_high_prio, tx_ok, tx_hold_frame, tx_bcast, tx_mcast;
  logic [2:0]       tx_deferred, tx_late_hit, tx_too_many_hits, half_duplex;
  logic [2:0][10:0] rx_len, tx_len;
  logic [2:0][4:0]  tx_hits;
  logic             e;
  int               err_total, samples_checked;
  psc_counters #(.NPORT(3)) u_psc_counters (.*);
  psc_host_model u_host (.*);
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [9:0] a, input int n);
    logic [31:0] x;
    u_host.rd_cnt(a, x);
    chk(x, {2'b01, 30'(n)});
  endtask : rc
  // rx flags: hold_op dest ctrl mcast bcast partial symbol check prio
  task automatic rxf(input int p, input int n, input logic [8:0] f);
    @(posedge pclk);
    rx_done[p] <= 1'b1;
    rx_len[p] <= 11'(n);
    {rx_hold_opcode[p], rx_dest_ok[p], rx_ctrl_type[p], rx_mcast[p], rx_bcast[p],
     rx_partial_byte[p], rx_symbol_bad[p], rx_check_bad[p], rx_high_prio[p]} <= f;
    @(posedge pclk);
    rx_done[p] <= 1'b0;
  endtask : rxf
  // tx flags: many late deferred mcast bcast hold ok prio
  task automatic txf(input int p, input int n, input logic [7:0] f, input int h);
    @(posedge pclk);
    tx_done[p] <= 1'b1;
    tx_len[p] <= 11'(n);
    tx_hits[p] <= 5'(h);
    {tx_too_many_hits[p], tx_late_hit[p], tx_deferred[p], tx_mcast[p], tx_bcast[p],
     tx_hold_frame[p], tx_ok[p], tx_high_prio[p]} <= f;
    @(posedge pclk);
    tx_done[p] <= 1'b0;
  endtask : txf
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #50us;
    err_total++;
    stop_test();
  end
  initial begin
    {rx_done, rx_high_prio, rx_check_bad, rx_symbol_bad, rx_partial_byte, rx_bcast,
     rx_mcast, rx_ctrl_type, rx_dest_ok, rx_hold_opcode, rx_len} = '0;
    {tx_done, tx_high_prio, tx_ok, tx_hold_frame, tx_bcast, tx_mcast, tx_deferred,
     tx_late_hit, tx_too_many_hits, tx_len, tx_hits} = '0;
    half_duplex = 3'h7;
    err_total = 0;
    samples_checked = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    u_host.xfer(1'b0, ADDR_MAX_LEN, 32'h0, v, e);
    chk(v, {21'h0, MAX_LEN_RST});
    u_host.xfer(1'b0, ADDR_DATA_HIGH, 32'h0, v, e);
    chk(v, 32'h0);
    u_host.xfer(1'b0, 8'h10, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    u_host.xfer(1'b1, ADDR_MAX_LEN, 32'hfff, v, e);
    u_host.xfer(1'b0, ADDR_MAX_LEN, 32'h0, v, e);
    chk(v, {21'h0, LEN_TOP});
    u_host.xfer(1'b1, ADDR_MAX_LEN, {21'h0, MAX_LEN_RST}, v, e);
    rxf(0, 64, 9'h000);
    rxf(0, 64, 9'h000);
    rxf(0, 64, 9'h010);
    rc(10'h00e, 3);
    rc(10'h00e, 0);
    rc(10'h000, 192);
    rc(10'h00d, 2);
    rc(10'h00b, 1);
    rxf(1, 100, 9'h001);
    rc(10'h021, 100);
    rc(10'h02f, 1);
    rc(10'h020, 0);
    rxf(0, 10, 9'h000);
    rc(10'h002, 1);
    rxf(0, 70, 9'h002);
    rc(10'h007, 1);
    rxf(0, 70, 9'h004);
    rc(10'h006, 1);
    rxf(0, 70, 9'h00a);
    rc(10'h008, 1);
    rxf(0, 1600, 9'h002);
    rc(10'h005, 1);
    rxf(0, 1600, 9'h000);
    rc(10'h004, 1);
    rc(10'h013, 2);
    rxf(0, 64, 9'h1e0);
    rc(10'h009, 1);
    rc(10'h00a, 1);
    rc(10'h00c, 0);
    txf(2, 100, 8'h62, 2);
    rc(10'h05c, 2);
    rc(10'h05f, 1);
    rc(10'h056, 1);
    rc(10'h05b, 1);
    rc(10'h054, 100);
    rc(10'h05a, 1);
    stop_test();
  end
endmodule : psc_counters_tb_top

// file: bench/psc_host_model.sv
// apb host model that reads counters through the indirect window
`timescale 1ns/1ps
module psc_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  import psc_pkg::*;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask : xfer
  task automatic rd_cnt(input logic [9:0] a, output logic [31:0] v);
    logic [31:0] h;
    logic [31:0] l;
    logic        e;
    xfer(1'b1, ADDR_ACCESS_CTRL, {19'h0, 3'h7, a}, h, e);
    xfer(1'b0, ADDR_DATA_HIGH, 32'h0, h, e);
    for (int i = 0; i < 4 && h[14] !== 1'b1; i++) xfer(1'b0, ADDR_DATA_HIGH, 32'h0, h, e);
    xfer(1'b0, ADDR_DATA_LOW, 32'h0, l, e);
    v = {h[15:0], l[15:0]};
  endtask : rd_cnt
endmodule : psc_host_model

// file: design/psc_counters.sv
// per-port statistics counter bank with indirect read-clear access over apb
//
// Overview of operation
// - thirty-two counters kept per port
// - bit 31 returns counter overflow flag
// - bit 30 returns count valid flag
// - bits 29-0 hold count, cleared on read
// - port blocks at 0x00, 0x20, 0x40
// - host reads via control, high, low words
// - rx octets by priority, bad included
// - short good frames; errored fragments
// - long good frames up to 2000
// - long errored frames beyond maximum size
// - bad symbol frames; bad check frames
// - misaligned frames with bad check
// - mac control ethertype frames counted
// - flow hold frames fully qualified
// - good rx broadcast, multicast, unicast
// - rx length histogram, six bins
// - tx good octets by priority
// - late hits; tx flow hold frames
// - good tx broadcast, multicast, unicast
// - deferred frames; all hits half duplex
// - failed, one hit, multi hit frames
`timescale 1ns/1ps
module psc_counters
  import psc_pkg::*;
#(
  parameter int NPORT = 3
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic                                    pready,
  output logic [31:0]                             prdata,
  output logic                                    pslverr,
  input  wire logic [NPORT-1:0]                   rx_done,
  input  wire logic [NPORT-1:0][psc_pkg::LEN_W-1:0] rx_len,
  input  wire logic [NPORT-1:0]                   rx_high_prio,
  input  wire logic [NPORT-1:0]                   rx_check_bad,
  input  wire logic [NPORT-1:0]                   rx_symbol_bad,
  input  wire logic [NPORT-1:0]                   rx_partial_byte,
  input  wire logic [NPORT-1:0]                   rx_bcast,
  input  wire logic [NPORT-1:0]                   rx_mcast,
  input  wire logic [NPORT-1:0]                   rx_ctrl_type,
  input  wire logic [NPORT-1:0]                   rx_dest_ok,
  input  wire logic [NPORT-1:0]                   rx_hold_opcode,
  input  wire logic [NPORT-1:0]                   tx_done,
  input  wire logic [NPORT-1:0][psc_pkg::LEN_W-1:0] tx_len,
  input  wire logic [NPORT-1:0]                   tx_high_prio,
  input  wire logic [NPORT-1:0]                   tx_ok,
  input  wire logic [NPORT-1:0]                   tx_hold_frame,
  input  wire logic [NPORT-1:0]                   tx_bcast,
  input  wire logic [NPORT-1:0]                   tx_mcast,
  input  wire logic [NPORT-1:0]                   tx_deferred,
  input  wire logic [NPORT-1:0]                   tx_late_hit,
  input  wire logic [NPORT-1:0]                   tx_too_many_hits,
  input  wire logic [NPORT-1:0][psc_pkg::HITS_W-1:0] tx_hits,
  input  wire logic [NPORT-1:0]                   half_duplex
);
  import psc_pkg::*;

  localparam int NENT = NPORT * CNT_PER_PORT;
  localparam int IDX_W = $clog2(MAX_PORTS * CNT_PER_PORT);

  initial begin
    if (NPORT < 1 || NPORT > MAX_PORTS) begin
      $error("psc_counters: NPORT must be 1 to 3");
    end
  end

  typedef struct packed {
    logic                  ovf;
    logic [CNT_W-1:0]      val;
  } psc_entry_t;

  typedef struct packed {
    psc_entry_t [NENT-1:0] cnt;
    logic [31:0]           data;
    logic                  pend;
    logic [IDX_W-1:0]      pend_idx;
    logic                  pend_hit;
    logic [IAC_W-1:0]      iac;
    logic [LEN_W-1:0]      max_len;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
  } psc_state_t;

  psc_state_t st_r;
  psc_state_t st_nxt;

  function automatic logic in_rng(input logic [LEN_W-1:0] len,
                                  input logic [LEN_W-1:0] lo,
                                  input logic [LEN_W-1:0] hi);
    in_rng = (len >= lo) && (len <= hi);
  endfunction : in_rng

  function automatic logic [CNT_W-1:0] ext(input logic b);
    ext = {{(CNT_W-1){1'b0}}, b};
  endfunction : ext

  // add to an entry; a read clear in the same cycle keeps only the new amount
  function automatic psc_entry_t bump(input psc_entry_t e,
                                      input logic [CNT_W-1:0] amt,
                                      input logic clr);
    logic [CNT_W:0] sum;
    psc_entry_t     r;
    sum = clr ? {1'b0, amt} : ({1'b0, e.val} + {1'b0, amt});
    r.val = sum[CNT_W-1:0];
    r.ovf = (clr ? 1'b0 : e.ovf) | sum[CNT_W];
    bump = r;
  endfunction : bump

  always_comb begin
    logic [CNT_W-1:0]   inc [CNT_PER_PORT];
    logic [LEN_W-1:0]   rl;
    logic [LEN_W-1:0]   tl;
    logic               rerr;
    logic               rgood;
    logic               acc;
    logic               wr;
    logic [IAC_W-1:0]   wv;
    logic [IDX_W-1:0]   idx;
    for (int i = 0; i < CNT_PER_PORT; i++) begin
      inc[i] = '0;
    end
    rl = '0;
    tl = '0;
    rerr = 1'b0;
    rgood = 1'b0;
    st_nxt = st_r;
    acc = psel && penable && !st_r.pready;
    wr = psel && penable && st_r.pready && pwrite;
    wv = pwdata[IAC_W-1:0];
    idx = wv[IDX_W-1:0];

    // counter updates; the pending read clears its entry this cycle
    for (int p = 0; p < NPORT; p++) begin
      for (int i = 0; i < CNT_PER_PORT; i++) begin
        inc[i] = '0;
      end
      rl = rx_len[p];
      tl = tx_len[p];
      rerr = rx_check_bad[p] || rx_symbol_bad[p];
      rgood = !rerr && in_rng(rl, LEN_MIN, st_r.max_len);
      if (rx_done[p]) begin
        inc[rx_high_prio[p] ? OFS_RX_HI_OCT : OFS_RX_LO_OCT] =
          {{(CNT_W-LEN_W){1'b0}}, rl};
        inc[OFS_RX_SHORT] = ext(rl < LEN_MIN && !rx_check_bad[p]);
        inc[OFS_RX_FRAG] = ext(rl < LEN_MIN && (rerr || rx_partial_byte[p]));
        inc[OFS_RX_LONG] = ext(rl > st_r.max_len && rl <= LEN_TOP
                               && !rx_check_bad[p]);
        inc[OFS_RX_LONG_ERR] = ext(rl > st_r.max_len && (rerr || rx_partial_byte[p]));
        inc[OFS_RX_BAD_SYM] = ext(rx_symbol_bad[p]
                                  && in_rng(rl, LEN_MIN, st_r.max_len));
        inc[OFS_RX_BAD_CHK] = ext(rx_check_bad[p] && !rx_partial_byte[p]
                                  && in_rng(rl, LEN_MIN, st_r.max_len));
        inc[OFS_RX_MISALIGN] = ext(rx_check_bad[p] && rx_partial_byte[p]
                                   && in_rng(rl, LEN_MIN, st_r.max_len));
        inc[OFS_RX_MAC_CTRL] = ext(rx_ctrl_type[p]);
        inc[OFS_RX_HOLD] = ext(rx_ctrl_type[p] && rx_dest_ok[p] && rx_hold_opcode[p]
                               && rl >= LEN_MIN && !rx_check_bad[p]);
        inc[OFS_RX_BCAST] = ext(rgood && rx_bcast[p]);
        inc[OFS_RX_MCAST] = ext(rgood && rx_mcast[p] && !rx_bcast[p]
                                && !rx_ctrl_type[p]);
        inc[OFS_RX_UCAST] = ext(rgood && !rx_mcast[p] && !rx_bcast[p]);
        inc[OFS_RX_HIST0] = ext(rl == LEN_MIN);
        inc[OFS_RX_HIST0+1] = ext(in_rng(rl, LEN_MIN + 11'h001, HIST_B1));
        inc[OFS_RX_HIST0+2] = ext(in_rng(rl, HIST_B1 + 11'h001, HIST_B2));
        inc[OFS_RX_HIST0+3] = ext(in_rng(rl, HIST_B2 + 11'h001, HIST_B3));
        inc[OFS_RX_HIST0+4] = ext(in_rng(rl, HIST_B3 + 11'h001, HIST_B4));
        inc[OFS_RX_HIST0+5] = ext(in_rng(rl, HIST_B4 + 11'h001, LEN_TOP));
      end
      if (tx_done[p]) begin
        if (tx_ok[p]) begin
          inc[tx_high_prio[p] ? OFS_TX_HI_OCT : OFS_TX_LO_OCT] =
            {{(CNT_W-LEN_W){1'b0}}, tl};
        end
        inc[OFS_TX_LATE] = ext(tx_late_hit[p]);
        inc[OFS_TX_HOLD] = ext(tx_ok[p] && tx_hold_frame[p]);
        inc[OFS_TX_BCAST] = ext(tx_ok[p] && tx_bcast[p]);
        inc[OFS_TX_MCAST] = ext(tx_ok[p] && tx_mcast[p] && !tx_bcast[p]);
        inc[OFS_TX_UCAST] = ext(tx_ok[p] && !tx_mcast[p] && !tx_bcast[p]);
        inc[OFS_TX_DEFER] = ext(tx_deferred[p]);
        inc[OFS_TX_ALL_HITS] = half_duplex[p] ?
          {{(CNT_W-HITS_W){1'b0}}, tx_hits[p]} : '0;
        inc[OFS_TX_FAIL] = ext(tx_too_many_hits[p]);
        inc[OFS_TX_ONE_HIT] = ext(tx_ok[p] && tx_hits[p] == 5'h01);
        inc[OFS_TX_MULTI] = ext(tx_ok[p] && tx_hits[p] > 5'h01);
      end
      for (int i = 0; i < CNT_PER_PORT; i++) begin
        st_nxt.cnt[p*PORT_BASE_STEP+i] =
          bump(st_r.cnt[p*PORT_BASE_STEP+i], inc[i],
               st_r.pend && st_r.pend_hit
               && st_r.pend_idx == IDX_W'(p*PORT_BASE_STEP+i));
      end
    end

    // finish a pending read: snapshot the entry, mark it valid
    if (st_r.pend) begin
      st_nxt.pend = 1'b0;
      if (st_r.pend_hit) begin
        st_nxt.data[ENT_OVF_BIT] = st_r.cnt[st_r.pend_idx].ovf;
        st_nxt.data[CNT_W-1:0] = st_r.cnt[st_r.pend_idx].val;
      end else begin
        st_nxt.data = '0;
      end
      st_nxt.data[ENT_VALID_BIT] = 1'b1;
    end

    // apb slave: one wait state, answer registered
    st_nxt.pready = acc;
    if (acc) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = '0;
      unique case (paddr)
        ADDR_ACCESS_CTRL: st_nxt.prdata = {{(32-IAC_W){1'b0}}, st_r.iac};
        ADDR_DATA_LOW:    st_nxt.prdata = {16'h0000, st_r.data[15:0]};
        ADDR_DATA_HIGH:   st_nxt.prdata = {16'h0000, st_r.data[31:16]};
        ADDR_MAX_LEN:     st_nxt.prdata = {{(32-LEN_W){1'b0}}, st_r.max_len};
        default:          st_nxt.pslverr = 1'b1;
      endcase
    end else begin
      // answer stands one cycle only; read data returns to zero after it
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = '0;
    end

    if (wr && paddr == ADDR_ACCESS_CTRL) begin
      st_nxt.iac = wv;
      if (wv[IAC_READ_BIT] && wv[IAC_SEL_HI:IAC_SEL_LO] == IAC_SEL_MIB) begin
        st_nxt.pend = 1'b1;
        st_nxt.pend_idx = idx;
        st_nxt.pend_hit = (wv[IAC_ADDR_W-1:0] < 10'(NENT));
        st_nxt.data[ENT_VALID_BIT] = 1'b0;
      end
    end
    if (wr && paddr == ADDR_MAX_LEN) begin
      st_nxt.max_len = (pwdata[LEN_W-1:0] > LEN_TOP) ? LEN_TOP : pwdata[LEN_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.max_len <= MAX_LEN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready  = st_r.pready;
  assign prdata  = st_r.prdata;
  assign pslverr = st_r.pslverr;

endmodule : psc_counters

// file: design/psc_pkg.sv
// shared constants for the port statistics counter bank
package psc_pkg;
  // apb register byte addresses
  localparam logic [7:0]  ADDR_ACCESS_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_DATA_LOW    = 8'h04;
  localparam logic [7:0]  ADDR_DATA_HIGH   = 8'h08;
  localparam logic [7:0]  ADDR_MAX_LEN     = 8'h0c;
  // indirect access control fields
  localparam int          IAC_READ_BIT     = 12;
  localparam int          IAC_SEL_HI       = 11;
  localparam int          IAC_SEL_LO       = 10;
  localparam logic [1:0]  IAC_SEL_MIB      = 2'h3;
  localparam int          IAC_ADDR_W       = 10;
  localparam int          IAC_W            = 13;
  // counter entry layout
  localparam int          ENT_OVF_BIT      = 31;
  localparam int          ENT_VALID_BIT    = 30;
  localparam int          CNT_W            = 30;
  localparam int          CNT_PER_PORT     = 32;
  localparam int          PORT_BASE_STEP   = 32;
  localparam int          MAX_PORTS        = 3;
  // counter offsets within a port block
  localparam int OFS_RX_LO_OCT   = 'h00;
  localparam int OFS_RX_HI_OCT   = 'h01;
  localparam int OFS_RX_SHORT    = 'h02;
  localparam int OFS_RX_FRAG     = 'h03;
  localparam int OFS_RX_LONG     = 'h04;
  localparam int OFS_RX_LONG_ERR = 'h05;
  localparam int OFS_RX_BAD_SYM  = 'h06;
  localparam int OFS_RX_BAD_CHK  = 'h07;
  localparam int OFS_RX_MISALIGN = 'h08;
  localparam int OFS_RX_MAC_CTRL = 'h09;
  localparam int OFS_RX_HOLD     = 'h0a;
  localparam int OFS_RX_BCAST    = 'h0b;
  localparam int OFS_RX_MCAST    = 'h0c;
  localparam int OFS_RX_UCAST    = 'h0d;
  localparam int OFS_RX_HIST0    = 'h0e;
  localparam int OFS_TX_LO_OCT   = 'h14;
  localparam int OFS_TX_HI_OCT   = 'h15;
  localparam int OFS_TX_LATE     = 'h16;
  localparam int OFS_TX_HOLD     = 'h17;
  localparam int OFS_TX_BCAST    = 'h18;
  localparam int OFS_TX_MCAST    = 'h19;
  localparam int OFS_TX_UCAST    = 'h1a;
  localparam int OFS_TX_DEFER    = 'h1b;
  localparam int OFS_TX_ALL_HITS = 'h1c;
  localparam int OFS_TX_FAIL     = 'h1d;
  localparam int OFS_TX_ONE_HIT  = 'h1e;
  localparam int OFS_TX_MULTI    = 'h1f;
  // frame length limits in octets
  localparam int          LEN_W            = 11;
  localparam logic [10:0] LEN_MIN          = 11'h040;
  localparam logic [10:0] LEN_TOP          = 11'h7d0;
  localparam logic [10:0] MAX_LEN_RST      = 11'h5f2;
  localparam logic [10:0] HIST_B1          = 11'h07f;
  localparam logic [10:0] HIST_B2          = 11'h0ff;
  localparam logic [10:0] HIST_B3          = 11'h1ff;
  localparam logic [10:0] HIST_B4          = 11'h3ff;
  localparam int          HITS_W           = 5;
endpackage : psc_pkg
